// >>> core/vfd_dec_pkg.sv
// constants and types for the serial command decoder of the two-line vfd
// assumes: one clock mclk at 200 MHz, host pins already synchronous to it
//
// How it works
// - serial bytes arrive least significant bit first, high level means one
// - data input is shifted in on each rising edge of the shift clock
// - while chip select is high, shift clock and data are ignored
// - reset zeroes pointers, digit field, duty and lights; RAM left undefined
// - two lines, each with code, user pattern and symbol stores of 16
// - opcode 1 or 9 writes a character code at the given digit
// - opcode 2 writes a user pattern from five interleaved seven-bit bytes
// - opcode 3 writes the symbol bit, bit zero of the next byte
// - opcode 5 sets duty: two low bits now, eight high bits next byte
// - opcode 6 sets the digit count from the low nibble
// - opcode 7: bit zero asks all off, bit one asks all on
// - brightness steps from 0 up to 960 of 1024, clamped above
// - one to sixteen digits are scanned, field zero meaning sixteen
// - standby stops the display timebase entirely
// - display timing comes from an internal 4 MHz timebase
// - all-off forces patterns dark, all-on forces them lit unless all-off is also set
// - further data bytes write the next RAM address automatically
// - framing restarts at select falling; eight bits make one byte
// - the four-bit RAM address wraps from fifteen to zero
package vfd_dec_pkg;
    // opcodes in bits 7..4 of a first byte, bit 4 the lowest;
    // bit 7 of a ram opcode picks line b
    localparam logic [3:0] OP_PAT_A = 4'h2;
    localparam logic [3:0] OP_PAT_B = 4'hA;
    localparam logic [3:0] OP_DIGITS = 4'h6;
    localparam logic [3:0] OP_CODE_A = 4'h1;
    localparam logic [3:0] OP_CODE_B = 4'h9;
    localparam logic [3:0] OP_DUTY = 4'h5;
    localparam logic [3:0] OP_SYM_A = 4'h3;
    localparam logic [3:0] OP_SYM_B = 4'hB;
    localparam logic [3:0] OP_LIGHTS = 4'h7;
    localparam logic [3:0] OP_STANDBY = 4'hF;
    // storage shape
    localparam int CODE_W = 8;
    localparam int PAT_W = 35;
    localparam int PAT_ROWS = 7;
    localparam int PAT_BYTES = 5;
    localparam logic [2:0] PAT_LAST = 3'h4;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // reset values
    localparam logic [3:0] ADDR_RST = 4'h0;
    localparam logic [9:0] DUTY_RST = 10'h000;
    localparam logic [3:0] DIGITS_RST = 4'h0;
    localparam logic [4:0] DIGITS_FULL = 5'h10;
    localparam logic [9:0] DUTY_MAX = 10'h3C0;
    // timing
    localparam int MCLK_HZ = 200_000_000;
    localparam int OSC_HZ = 4_000_000;
    localparam int OSC_DIV = MCLK_HZ / OSC_HZ;
    localparam logic [5:0] OSC_DIV_LAST = 6'(OSC_DIV - 1);
    typedef enum logic {
        ST_CMD = 1'b0,
        ST_DATA = 1'b1
    } dec_state_t;
endpackage

// >>> core/vfd_ram16.sv
// sixteen-entry store with one write port and a registered read port
// assumes: write and read share mclk; contents are not reset
`timescale 1ns/1ps
`default_nettype none
module vfd_ram16 #(
    parameter int WIDTH = 8
) (
    input wire logic mclk, // system clock
    input wire logic we, // write strobe
    input wire logic [3:0] waddr, // write address
    input wire logic [WIDTH-1:0] wdata, // write data
    input wire logic [3:0] raddr, // read address
    output logic [WIDTH-1:0] rdata_q // registered read data
);
    logic [WIDTH-1:0] mem [16];

    // write port
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // read port, one cycle latency
    always_ff @(posedge mclk) begin
        rdata_q <= mem[raddr];
    end
endmodule
`default_nettype wire

// >>> core/vfd_serial_command_decoder.sv
// serial byte receiver, command decoder, per-line stores and settings
// assumes: host pins synchronous to mclk, shift clock well below mclk
`timescale 1ns/1ps
`default_nettype none
module vfd_serial_command_decoder (
    input wire logic mclk, // 200 MHz clock
    input wire logic rst, // synchronous reset, high
    input wire logic host_reset_n, // host reset pin, low
    input wire logic chip_select_n, // select, low enables transfer
    input wire logic serial_shift_clock, // shift clock
    input wire logic serial_data_in, // serial data, lsb first
    input wire logic [3:0] scan_digit_addr, // digit read address
    input wire logic [3:0] scan_pat_addr_a, // line a pattern read addr
    input wire logic [3:0] scan_pat_addr_b, // line b pattern read addr
    output logic [7:0] line_a_code_q, // line a character code
    output logic [7:0] line_b_code_q, // line b character code
    output logic [34:0] line_a_anode_q, // line a pattern after override
    output logic [34:0] line_b_anode_q, // line b pattern after override
    output logic line_a_symbol_output_q, // line a symbol after override
    output logic line_b_symbol_output_q, // line b symbol after override
    output logic [9:0] duty_value_bits_q, // programmed duty
    output logic [9:0] duty_level_q, // clamped duty
    output logic [3:0] digit_count_bits_q, // programmed digit field
    output logic [4:0] scan_digits_q, // digits scanned, 1..16
    output logic all_on_q, // all-lights on request
    output logic all_off_q, // all-lights off request
    output logic standby_q, // standby active
    output logic display_tick_q // 4 MHz display timebase pulse
);
    import vfd_dec_pkg::*;

    logic rst_all;
    logic sclk_prev_q;
    logic sclk_rise;
    logic [2:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] shift_in;
    logic byte_done;
    logic is_first;
    logic is_data;
    logic entry_done;
    logic op_known;
    logic op_ram;
    logic [3:0] op;
    dec_state_t state_q;
    logic [3:0] cmd_q;
    logic [3:0] addr_q;
    logic [1:0] duty_lo_q;
    logic [2:0] pat_idx_q;
    logic [PAT_W-1:0] pat_acc_q;
    logic [PAT_W-1:0] pat_next;
    logic wr_line_q;
    logic wr_code_q;
    logic wr_pat_q;
    logic wr_sym_q;
    logic [3:0] wr_addr_q;
    logic [7:0] wr_byte_q;
    logic [PAT_W-1:0] wr_pattern_q;
    logic [5:0] div_q;
    logic [CODE_W-1:0] code_rd [2];
    logic [PAT_W-1:0] pat_rd [2];
    logic sym_rd [2];

    // byte framing and decode strobes
    always_comb begin
        rst_all = rst | ~host_reset_n;
        sclk_rise = serial_shift_clock & ~sclk_prev_q;
        shift_in = {serial_data_in, shift_q[7:1]};
        byte_done = sclk_rise & ~chip_select_n & (bit_cnt_q == BIT_LAST);
        is_first = byte_done & (state_q == ST_CMD);
        is_data = byte_done & (state_q == ST_DATA);
        op = shift_in[7:4];
        op_ram = (op == OP_CODE_A) | (op == OP_CODE_B) | (op == OP_PAT_A)
            | (op == OP_PAT_B) | (op == OP_SYM_A) | (op == OP_SYM_B);
        op_known = op_ram | (op == OP_DUTY) | (op == OP_DIGITS)
            | (op == OP_LIGHTS) | (op == OP_STANDBY);
        entry_done = is_data & (cmd_q != OP_DUTY)
            & (((cmd_q != OP_PAT_A) & (cmd_q != OP_PAT_B))
            | (pat_idx_q == PAT_LAST));
    end

    // interleaved pattern merge: byte n carries bits n, n+5, ... n+30
    always_comb begin
        pat_next = pat_acc_q;
        for (int k = 0; k < PAT_ROWS; k++) begin
            pat_next[int'(pat_idx_q) + PAT_BYTES * k] = shift_in[k];
        end
    end

    // shift register and bit counter
    always_ff @(posedge mclk) begin
        sclk_prev_q <= serial_shift_clock;
        if (rst_all || chip_select_n) begin
            bit_cnt_q <= 3'h0;
            shift_q <= 8'h00;
        end else if (sclk_rise) begin
            bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
            shift_q <= shift_in;
        end
    end

    // command state: select high ends the command
    always_ff @(posedge mclk) begin
        if (rst_all || chip_select_n) begin
            state_q <= ST_CMD;
        end else if (is_first) begin
            state_q <= (op_ram || op == OP_DUTY) ? ST_DATA : ST_CMD;
        end else if (is_data && cmd_q == OP_DUTY) begin
            state_q <= ST_CMD;
        end
    end

    // opcode latch, ram pointer and pattern accumulator
    always_ff @(posedge mclk) begin
        if (rst_all) begin
            cmd_q <= 4'h0;
            addr_q <= ADDR_RST;
            pat_idx_q <= 3'h0;
            pat_acc_q <= '0;
        end else if (is_first) begin
            if (op_known) begin
                cmd_q <= op;
            end
            if (op_ram) begin
                addr_q <= shift_in[3:0];
            end
            pat_idx_q <= 3'h0;
        end else if (is_data) begin
            if (entry_done) begin
                addr_q <= 4'(addr_q + 4'h1);
            end
            if (cmd_q == OP_PAT_A || cmd_q == OP_PAT_B) begin
                pat_acc_q <= pat_next;
                pat_idx_q <= (pat_idx_q == PAT_LAST) ? 3'h0
                    : 3'(pat_idx_q + 3'h1);
            end
        end
    end

    // write strobes toward the per-line stores
    always_ff @(posedge mclk) begin
        if (rst_all) begin
            wr_code_q <= 1'b0;
            wr_pat_q <= 1'b0;
            wr_sym_q <= 1'b0;
            wr_line_q <= 1'b0;
            wr_addr_q <= 4'h0;
            wr_byte_q <= 8'h00;
            wr_pattern_q <= '0;
        end else begin
            wr_code_q <= entry_done
                & (cmd_q == OP_CODE_A || cmd_q == OP_CODE_B);
            wr_pat_q <= entry_done
                & (cmd_q == OP_PAT_A || cmd_q == OP_PAT_B);
            wr_sym_q <= entry_done
                & (cmd_q == OP_SYM_A || cmd_q == OP_SYM_B);
            wr_line_q <= cmd_q[3];
            wr_addr_q <= addr_q;
            wr_byte_q <= shift_in;
            wr_pattern_q <= pat_next;
        end
    end

    // per-line stores
    for (genvar ln = 0; ln < 2; ln++) begin : g_line
        vfd_ram16 #(.WIDTH(CODE_W)) u_code (
            .mclk(mclk),
            .we(wr_code_q && (wr_line_q == 1'(ln))),
            .waddr(wr_addr_q),
            .wdata(wr_byte_q),
            .raddr(scan_digit_addr),
            .rdata_q(code_rd[ln])
        );
        vfd_ram16 #(.WIDTH(PAT_W)) u_pat (
            .mclk(mclk),
            .we(wr_pat_q && (wr_line_q == 1'(ln))),
            .waddr(wr_addr_q),
            .wdata(wr_pattern_q),
            .raddr(ln == 0 ? scan_pat_addr_a : scan_pat_addr_b),
            .rdata_q(pat_rd[ln])
        );
        vfd_ram16 #(.WIDTH(1)) u_sym (
            .mclk(mclk),
            .we(wr_sym_q && (wr_line_q == 1'(ln))),
            .waddr(wr_addr_q),
            .wdata(wr_byte_q[0:0]),
            .raddr(scan_digit_addr),
            .rdata_q(sym_rd[ln])
        );
    end

    // display outputs with the all-lights override
    always_ff @(posedge mclk) begin
        line_a_code_q <= code_rd[0];
        line_b_code_q <= code_rd[1];
        if (rst_all || all_off_q) begin
            line_a_anode_q <= '0;
            line_b_anode_q <= '0;
            line_a_symbol_output_q <= 1'b0;
            line_b_symbol_output_q <= 1'b0;
        end else if (all_on_q) begin
            line_a_anode_q <= '1;
            line_b_anode_q <= '1;
            line_a_symbol_output_q <= 1'b1;
            line_b_symbol_output_q <= 1'b1;
        end else begin
            line_a_anode_q <= pat_rd[0];
            line_b_anode_q <= pat_rd[1];
            line_a_symbol_output_q <= sym_rd[0];
            line_b_symbol_output_q <= sym_rd[1];
        end
    end

    // settings written by single-byte and duty commands
    always_ff @(posedge mclk) begin
        if (rst_all) begin
            duty_lo_q <= 2'h0;
            duty_value_bits_q <= DUTY_RST;
            digit_count_bits_q <= DIGITS_RST;
            all_on_q <= 1'b0;
            all_off_q <= 1'b0;
            standby_q <= 1'b0;
        end else if (is_first && op_known) begin
            standby_q <= (op == OP_STANDBY);
            if (op == OP_DUTY) begin
                duty_lo_q <= shift_in[1:0];
            end
            if (op == OP_DIGITS) begin
                digit_count_bits_q <= shift_in[3:0];
            end
            if (op == OP_LIGHTS) begin
                all_off_q <= shift_in[0];
                all_on_q <= shift_in[1];
            end
        end else if (is_data && cmd_q == OP_DUTY) begin
            duty_value_bits_q <= {shift_in, duty_lo_q};
        end
    end

    // derived brightness and digit span
    always_ff @(posedge mclk) begin
        if (rst_all) begin
            duty_level_q <= DUTY_RST;
            scan_digits_q <= DIGITS_FULL;
        end else begin
            duty_level_q <= (duty_value_bits_q > DUTY_MAX) ? DUTY_MAX
                : duty_value_bits_q;
            scan_digits_q <= (digit_count_bits_q == 4'h0) ? DIGITS_FULL
                : {1'b0, digit_count_bits_q};
        end
    end

    // display timebase, halted in standby
    always_ff @(posedge mclk) begin
        if (rst_all || standby_q) begin
            div_q <= 6'h00;
            display_tick_q <= 1'b0;
        end else begin
            div_q <= (div_q == OSC_DIV_LAST) ? 6'h00 : 6'(div_q + 6'h01);
            display_tick_q <= (div_q == OSC_DIV_LAST);
        end
    end

    sequence seq_first_op(logic [3:0] o);
        is_first && op == o;
    endsequence

    chk_select_ignores: assert property (@(posedge mclk)
        disable iff (rst_all) chip_select_n |=> bit_cnt_q == 3'h0 && !is_data)
        else $error("select high did not hold framing idle");
    chk_shift_edge_msb: assert property (@(posedge mclk)
        disable iff (rst_all) sclk_rise && !chip_select_n
        |=> shift_q[7] == $past(serial_data_in))
        else $error("data not sampled on shift clock rise");
    chk_reset_init: assert property (@(posedge mclk)
        rst |=> duty_value_bits_q == DUTY_RST && addr_q == ADDR_RST
        && digit_count_bits_q == DIGITS_RST && !all_on_q && !all_off_q)
        else $error("reset values wrong");
    chk_digit_set: assert property (@(posedge mclk)
        disable iff (rst_all) seq_first_op(OP_DIGITS)
        |=> digit_count_bits_q == $past(shift_in[3:0])
        ##1 scan_digits_q == (digit_count_bits_q == 4'h0 ? DIGITS_FULL
        : {1'b0, digit_count_bits_q}))
        else $error("digit count not taken");
    chk_lights_set: assert property (@(posedge mclk)
        disable iff (rst_all) seq_first_op(OP_LIGHTS)
        |=> all_off_q == $past(shift_in[0]) && all_on_q == $past(shift_in[1]))
        else $error("lights request not taken");
    chk_lights_force: assert property (@(posedge mclk)
        disable iff (rst_all) all_on_q && !all_off_q
        |=> line_a_anode_q == '1 && line_b_symbol_output_q)
        else $error("all-on did not light outputs");
    chk_duty_clamp: assert property (@(posedge mclk)
        disable iff (rst_all) ##1 duty_level_q == ($past(duty_value_bits_q)
        > DUTY_MAX ? DUTY_MAX : $past(duty_value_bits_q)))
        else $error("duty level not clamped to 960");
    chk_addr_wrap: assert property (@(posedge mclk)
        disable iff (rst_all) entry_done && addr_q == 4'hF |=> addr_q == 4'h0)
        else $error("ram address did not wrap");
    chk_auto_incr: assert property (@(posedge mclk)
        disable iff (rst_all) entry_done
        |=> addr_q == 4'($past(addr_q) + 4'h1) && wr_addr_q == $past(addr_q))
        else $error("address did not advance after entry");
    chk_unknown_op: assert property (@(posedge mclk)
        disable iff (rst_all) is_first && !op_known
        |=> $stable(duty_value_bits_q) && $stable(standby_q)
        && state_q == ST_CMD && $stable(addr_q))
        else $error("undefined opcode changed state");
    chk_standby_halt: assert property (@(posedge mclk)
        disable iff (rst_all) standby_q |=> !display_tick_q [*3])
        else $error("timebase ran in standby");
    chk_tick_spacing: assert property (@(posedge mclk)
        disable iff (rst_all) display_tick_q |=> !display_tick_q [*8])
        else $error("timebase pulses too close");
endmodule
`default_nettype wire

// >>> sim/vfd_host_model.sv
// host side model: drives select, shift clock and serial data
// assumes: bench calls the tasks; pins change just after mclk rises
`timescale 1ns/1ps
`default_nettype none
module vfd_host_model (
    input wire logic mclk, // system clock
    output logic chip_select_n, // select, low active
    output logic serial_shift_clock, // shift clock, rests low
    output logic serial_data_in // serial data
);
    logic busy;
    int pace = 1;
    // idle pins at time zero
    initial begin
        chip_select_n = 1'b1;
        serial_shift_clock = 1'b0;
        serial_data_in = 1'b0;
        busy = 1'b0;
    end
    // data line is not driven outside bytes: show a changing pattern
    always @(posedge mclk) begin
        if (!busy) begin
            serial_data_in <= ~serial_data_in;
        end
    end
    // move select; low opens a transfer, high closes it
    task automatic sel(input logic v);
        @(posedge mclk);
        chip_select_n <= v;
    endtask
    // shift n bits, least significant first, high level is one
    task automatic put_bits(input logic [7:0] b, input int n);
        @(posedge mclk);
        busy <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            serial_shift_clock <= 1'b0;
            serial_data_in <= b[i];
            repeat (pace) @(posedge mclk);
            serial_shift_clock <= 1'b1;
            repeat (pace) @(posedge mclk);
        end
        @(posedge mclk);
        serial_shift_clock <= 1'b0;
        busy <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> sim/vfd_serial_command_decoder_test.sv
// self-checking bench for the serial command decoder
// assumes: host model drives the serial pins, bench drives the rest
`timescale 1ns/1ps
`default_nettype none
module vfd_serial_command_decoder_test;
    import vfd_dec_pkg::*;
    logic mclk;
    logic rst;
    logic host_reset_n;
    logic [3:0] dig_addr;
    logic [3:0] pat_a;
    logic [3:0] pat_b;
    wire logic cs_n;
    wire logic sclk;
    wire logic sdat;
    logic [7:0] code_a;
    logic [7:0] code_b;
    logic [34:0] anode_a;
    logic [34:0] anode_b;
    logic sym_a;
    logic sym_b;
    logic [9:0] duty;
    logic [9:0] level;
    logic [3:0] dig;
    logic [4:0] digits;
    logic on;
    logic off;
    logic sb;
    logic tick;
    logic [9:0] e_duty = 10'h000;
    logic [3:0] e_dig = 4'h0;
    logic e_on = 1'b0;
    logic e_off = 1'b0;
    logic e_sb = 1'b0;
    logic [34:0] pk[2][2];
    logic [9:0] dv[$] = '{10'h000, 10'h3BF, 10'h3C0, 10'h3C1, 10'h3FF};
    logic [7:0] lb[5] = '{8'h71, 8'h72, 8'h7E, 8'h73, 8'h70};
    logic [3:0] ub[6] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'hD, 4'hE};
    int errors = 0;
    int num_checks = 0;
    vfd_host_model host (.mclk(mclk), .chip_select_n(cs_n),
        .serial_shift_clock(sclk), .serial_data_in(sdat));
    vfd_serial_command_decoder dut (.mclk(mclk), .rst(rst),
        .host_reset_n(host_reset_n), .chip_select_n(cs_n),
        .serial_shift_clock(sclk), .serial_data_in(sdat),
        .scan_digit_addr(dig_addr), .scan_pat_addr_a(pat_a),
        .scan_pat_addr_b(pat_b), .line_a_code_q(code_a),
        .line_b_code_q(code_b), .line_a_anode_q(anode_a),
        .line_b_anode_q(anode_b), .line_a_symbol_output_q(sym_a),
        .line_b_symbol_output_q(sym_b), .duty_value_bits_q(duty),
        .duty_level_q(level), .digit_count_bits_q(dig),
        .scan_digits_q(digits), .all_on_q(on), .all_off_q(off),
        .standby_q(sb), .display_tick_q(tick));
    // 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic give_verdict();
        if (errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check_val(input logic [34:0] got, input logic [34:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_count(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // all settings against the expected copies
    task automatic chk_set();
        check_val(duty, e_duty);
        check_val(level, e_duty > 10'h3C0 ? 10'h3C0 : e_duty);
        check_val(dig, e_dig);
        check_val(digits, e_dig == 4'h0 ? 5'h10 : {1'b0, e_dig});
        check_val(on, e_on);
        check_val(off, e_off);
        check_val(sb, e_sb);
    endtask
    // one selected frame of whole bytes
    task automatic send(input logic [7:0] q[$]);
        host.sel(1'b0);
        foreach (q[i]) host.put_bits(q[i], 8);
        host.sel(1'b1);
        repeat (4) @(posedge mclk);
        #1;
    endtask
    // point all read addresses at a and let the reads settle
    task automatic look(input logic [3:0] a);
        @(posedge mclk);
        dig_addr <= a;
        pat_a <= a;
        pat_b <= a;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic count_ticks(input int exp);
        int n;
        n = 0;
        repeat (500) begin
            @(posedge mclk);
            #1;
            if (tick === 1'b1) n++;
        end
        check_count(n, exp);
    endtask
    // pattern byte n carries bits n, n+5, ..; top bit set, must be ignored
    function automatic logic [7:0] pat_byte(input logic [34:0] p, input int n);
        logic [7:0] b;
        b = 8'h80;
        for (int k = 0; k < 7; k++) b[k] = p[n + 5 * k];
        return b;
    endfunction
    // hang guard
    initial begin
        repeat (100000) @(posedge mclk);
        errors++;
        give_verdict();
    end
    initial begin
        logic [7:0] q[$];
        void'($urandom(32'h507B4094));
        rst = 1'b1;
        host_reset_n = 1'b1;
        dig_addr = 4'h0;
        pat_a = 4'h0;
        pat_b = 4'h0;
        repeat (2) @(posedge mclk);
        #1;
        chk_set();
        check_val(anode_a, 35'h0);
        @(posedge mclk);
        rst <= 1'b0;
        host.put_bits(8'h6C, 8);
        repeat (3) @(posedge mclk);
        #1;
        chk_set();
        for (int k = 0; k < 16; k++) begin
            send('{{OP_DIGITS, 4'(k)}});
            e_dig = 4'(k);
            chk_set();
        end
        host.pace = 3;
        repeat (4) dv.push_back(10'($urandom));
        foreach (dv[i]) begin
            send('{{OP_DUTY, 2'($urandom), dv[i][1:0]}, dv[i][9:2]});
            e_duty = dv[i];
            chk_set();
        end
        host.pace = 1;
        host.sel(1'b0);
        host.put_bits(8'h67, 5);
        host.sel(1'b1);
        repeat (3) @(posedge mclk);
        #1;
        chk_set();
        send('{8'h65});
        e_dig = 4'h5;
        chk_set();
        // per line: codes from E with wrap, two patterns from F, symbols
        for (int ln = 0; ln < 2; ln++) begin
            q.delete();
            q.push_back({ln ? OP_CODE_B : OP_CODE_A, 4'hE});
            repeat (4) q.push_back(8'($urandom));
            send(q);
            for (int j = 0; j < 4; j++) begin
                look(4'hE + 4'(j));
                check_val(ln ? code_b : code_a, q[j + 1]);
            end
            q.delete();
            q.push_back({ln ? OP_PAT_B : OP_PAT_A, 4'hF});
            for (int g = 0; g < 2; g++) begin
                pk[ln][g] = {3'($urandom), $urandom};
                for (int n = 0; n < 5; n++) q.push_back(pat_byte(pk[ln][g], n));
            end
            send(q);
            for (int g = 0; g < 2; g++) begin
                look(4'hF + 4'(g));
                check_val(ln ? anode_b : anode_a, pk[ln][g]);
            end
            send('{{ln ? OP_SYM_B : OP_SYM_A, 4'hE}, 8'hFE, 8'h01});
            look(4'hE);
            check_val(ln ? sym_b : sym_a, 1'b0);
            look(4'hF);
            check_val(ln ? sym_b : sym_a, 1'b1);
        end
        foreach (lb[i]) begin
            send('{lb[i]});
            e_off = lb[i][0];
            e_on = lb[i][1];
            chk_set();
            look(4'hF);
            check_val(anode_a, e_off ? 35'h0 : e_on ? {35{1'b1}} : pk[0][0]);
            check_val(sym_a, e_off ? 1'b0 : 1'b1);
        end
        foreach (ub[i]) begin
            send('{{ub[i], 4'hF}});
            chk_set();
        end
        send('{8'hF3});
        e_sb = 1'b1;
        chk_set();
        count_ticks(0);
        send('{8'h60});
        e_sb = 1'b0;
        e_dig = 4'h0;
        chk_set();
        count_ticks(10);
        send('{8'h69});
        send('{8'h71});
        @(posedge mclk);
        host_reset_n <= 1'b0;
        @(posedge mclk);
        host_reset_n <= 1'b1;
        #1;
        e_duty = 10'h000;
        e_dig = 4'h0;
        e_off = 1'b0;
        e_on = 1'b0;
        chk_set();
        check_val(anode_b, 35'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
